// ---- bench/gp_timer_32bit_modes_tb.sv ----
// Self-checking bench of the general timer module in joined timer, split and RTC modes.
// Assumes a 40 MHz clock and a shortened RTC divide of 4 pin edges per step.
`include "gp_timer_defs.svh"
module gp_timer_32bit_modes_tb
	import gp_timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0;
	logic rst = 1;
	logic [7:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [31:0] reg_rdata;
	logic debug_halt = 0;
	logic capture_pin_zero = 0;
	logic adc_trigger_in = 0;
	logic adc_trigger;
	logic timer_irq;
	int error_cnt = 0;
	int checked = 0;
	int trig_cnt = 0;
	int base;
	logic [31:0] v1;
	logic [31:0] v2;

	gp_timer_32bit_modes #(.RTC_EDGES_PER_SECOND(4)) dut (
		.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_halt(debug_halt), .capture_pin_zero(capture_pin_zero),
		.adc_trigger_in(adc_trigger_in), .adc_trigger(adc_trigger), .timer_irq(timer_irq)
	);

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (adc_trigger === 1'b1) trig_cnt++;
	end

	// ----------------------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		chk(v, exp);
	endtask
	task automatic wait_raw(input int idx);
		logic [31:0] v;
		v = '0;
		for (int i = 0; i < 40 && v[idx] !== 1'b1; i++) rd(`OFS_RAW_STATUS, v);
	endtask
	task automatic pin_edges(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk_sys);
			capture_pin_zero <= 1'b1;
			repeat (4) @(posedge clk_sys);
			capture_pin_zero <= 1'b0;
		end
		repeat (8) @(posedge clk_sys);
	endtask

	// ----------------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------------
	task automatic t_reset;
		rdchk(`OFS_CONFIG, 32'h0);
		rdchk(`OFS_CONTROL, 32'h0);
		rdchk(`OFS_FIRST_LOAD, 32'hffffffff);
		rdchk(`OFS_SECOND_LOAD, 32'h0000ffff);
		rdchk(`OFS_FIRST_COUNT, 32'hffffffff);
		rdchk(`OFS_FIRST_PRESCALE, 32'h0);
		rdchk(`OFS_SECOND_PRESCALE, 32'h0);
		rdchk(8'h10, 32'h0);
		@(posedge clk_sys);
		adc_trigger_in <= 1'b1;
		@(posedge clk_sys);
		adc_trigger_in <= 1'b0;
		#1 chk({31'h0, adc_trigger}, 32'h1);
	endtask
	task automatic t_concat;
		wr(`OFS_FIRST_LOAD, 32'h00050003);
		rdchk(`OFS_SECOND_LOAD, 32'h5);
		rdchk(`OFS_FIRST_LOAD, 32'h00050003);
		rdchk(`OFS_FIRST_COUNT, 32'h00050003);
	endtask
	task automatic t_oneshot;
		base = trig_cnt;
		wr(`OFS_FIRST_LOAD, 32'h3);
		wr(`OFS_FIRST_MODE, 32'h1);
		wr(`OFS_SECOND_MODE, 32'h2);
		wr(`OFS_CONTROL, 32'h21);
		wait_raw(0);
		rdchk(`OFS_CONTROL, 32'h20);
		rdchk(`OFS_FIRST_COUNT, 32'h3);
		chk(32'(trig_cnt - base), 32'h1);
		repeat (5) @(posedge clk_sys);
		rdchk(`OFS_RAW_STATUS, 32'h1);
		wr(`OFS_IRQ_CLEAR, 32'h1);
		rdchk(`OFS_RAW_STATUS, 32'h0);
	endtask
	task automatic t_periodic;
		base = trig_cnt;
		wr(`OFS_IRQ_MASK, 32'h1);
		wr(`OFS_FIRST_MODE, 32'h2);
		wr(`OFS_SECOND_MODE, 32'h1);
		wr(`OFS_CONTROL, 32'h1);
		wait_raw(0);
		repeat (12) @(posedge clk_sys);
		rdchk(`OFS_CONTROL, 32'h1);
		rdchk(`OFS_MASKED_STATUS, 32'h1);
		chk({31'h0, timer_irq}, 32'h1);
		chk(32'(trig_cnt - base), 32'h0);
		wr(`OFS_CONTROL, 32'h0);
		wr(`OFS_IRQ_CLEAR, 32'h1);
		rdchk(`OFS_RAW_STATUS, 32'h0);
		chk({31'h0, timer_irq}, 32'h0);
		wr(`OFS_IRQ_MASK, 32'h0);
	endtask
	task automatic t_freeze;
		wr(`OFS_FIRST_LOAD, 32'h100);
		wr(`OFS_CONTROL, 32'h3);
		@(posedge clk_sys);
		debug_halt <= 1'b1;
		rd(`OFS_FIRST_COUNT, v1);
		repeat (4) @(posedge clk_sys);
		rdchk(`OFS_FIRST_COUNT, v1);
		@(posedge clk_sys);
		debug_halt <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd(`OFS_FIRST_COUNT, v2);
		chk({31'h0, v2 < v1}, 32'h1);
		wr(`OFS_FIRST_LOAD, 32'h80);
		rdchk(`OFS_FIRST_COUNT, 32'h80);
		wr(`OFS_CONTROL, 32'h0);
	endtask
	task automatic t_rtc;
		wr(`OFS_FIRST_MATCH, 32'h2);
		wr(`OFS_CONFIG, 32'h1);
		rdchk(`OFS_FIRST_COUNT, 32'h1);
		wr(`OFS_CONTROL, 32'h13);
		debug_halt <= 1'b1;
		pin_edges(4);
		rdchk(`OFS_FIRST_COUNT, 32'h2);
		wr(`OFS_IRQ_MASK, 32'h8);
		pin_edges(4);
		rdchk(`OFS_FIRST_COUNT, 32'h0);
		rdchk(`OFS_RAW_STATUS, 32'h8);
		rdchk(`OFS_MASKED_STATUS, 32'h8);
		chk({31'h0, timer_irq}, 32'h1);
		wr(`OFS_IRQ_CLEAR, 32'h8);
		rdchk(`OFS_RAW_STATUS, 32'h0);
		rdchk(`OFS_MASKED_STATUS, 32'h0);
		@(posedge clk_sys);
		debug_halt <= 1'b0;
	endtask
	task automatic t_split;
		wr(`OFS_CONTROL, 32'h0);
		wr(`OFS_CONFIG, 32'h4);
		wr(`OFS_FIRST_LOAD, 32'h2);
		wr(`OFS_SECOND_LOAD, 32'h5);
		wr(`OFS_FIRST_MODE, 32'h1);
		wr(`OFS_SECOND_MODE, 32'h2);
		base = trig_cnt;
		wr(`OFS_CONTROL, 32'h2101);
		repeat (20) @(posedge clk_sys);
		rdchk(`OFS_CONTROL, 32'h2100);
		rdchk(`OFS_RAW_STATUS, 32'h101);
		rdchk(`OFS_FIRST_COUNT, 32'h2);
		chk({31'h0, trig_cnt != base}, 32'h1);
		wr(`OFS_CONTROL, 32'h0);
	endtask

	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		#500us;
		error_cnt++;
		print_verdict;
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset;
		t_concat;
		t_oneshot;
		t_periodic;
		t_freeze;
		t_rtc;
		t_split;
		print_verdict;
	end
endmodule // gp_timer_32bit_modes_tb

// ---- bench/gp_timer_asserts.sv ----
// Concurrent checks on the port behaviour of the general timer module.
// Assumes the register map of gp_timer_defs.svh and a master that never overlaps strobes.
`include "gp_timer_defs.svh"
module gp_timer_asserts
	import gp_timer_pkg::*;
#(
	parameter int RTC_EDGES_PER_SECOND = 4
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic debug_halt,
	input wire logic capture_pin_zero,
	input wire logic adc_trigger_in,
	input wire logic adc_trigger,
	input wire logic timer_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------------------
	// Shadow of what software wrote
	// ----------------------------------------------------------------------------
	logic [2:0] cfg_reg;
	logic [13:0] ctl_reg;
	logic [2:0] mask_reg;
	logic [31:0] load_reg;
	logic pre_wr_reg;
	logic ctl_wr_reg;
	logic sync_reg;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_reg <= `CONFIG_RESET;
			ctl_reg <= '0;
			mask_reg <= '0;
			load_reg <= 32'hffffffff;
			pre_wr_reg <= 1'b0;
			ctl_wr_reg <= 1'b0;
			sync_reg <= 1'b1;
		end else if (reg_wr) begin
			case (reg_addr)
				`OFS_CONFIG: begin
					cfg_reg <= reg_wdata[2:0];
					sync_reg <= 1'b0;
				end
				`OFS_CONTROL: begin
					ctl_reg <= reg_wdata[13:0];
					ctl_wr_reg <= 1'b1;
					if (reg_wdata[0]) sync_reg <= 1'b0;
				end
				`OFS_IRQ_MASK: mask_reg <= {reg_wdata[8], reg_wdata[3], reg_wdata[0]};
				`OFS_FIRST_LOAD: begin
					if (cfg_reg < 3'h2) load_reg <= reg_wdata;
					else load_reg[15:0] <= reg_wdata[15:0];
					if (!ctl_reg[0]) sync_reg <= 1'b1;
				end
				`OFS_SECOND_LOAD: begin
					load_reg[31:16] <= reg_wdata[15:0];
					sync_reg <= 1'b0;
				end
				`OFS_FIRST_PRESCALE, `OFS_SECOND_PRESCALE: pre_wr_reg <= 1'b1;
				default: ;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------------------
	property p_prescale_reset;
		reg_rd && !pre_wr_reg && (reg_addr == `OFS_FIRST_PRESCALE || reg_addr == `OFS_SECOND_PRESCALE)
			|=> reg_rdata == 32'h0;
	endproperty
	a_prescale_reset: assert property (p_prescale_reset) else $error("prescale not zero after reset");
	property p_control_reset;
		reg_rd && reg_addr == `OFS_CONTROL && !ctl_wr_reg |=> reg_rdata == 32'h0;
	endproperty
	a_control_reset: assert property (p_control_reset) else $error("control not clear after reset");
	property p_config_read;
		reg_rd && reg_addr == `OFS_CONFIG |=> reg_rdata == {29'h0, cfg_reg};
	endproperty
	a_config_read: assert property (p_config_read) else $error("config readback wrong");
	property p_load_join;
		reg_rd && reg_addr == `OFS_FIRST_LOAD && cfg_reg < 3'h2 |=> reg_rdata == load_reg;
	endproperty
	a_load_join: assert property (p_load_join) else $error("joined load readback wrong");
	property p_count_join;
		reg_rd && !$past(reg_wr) && reg_addr == `OFS_FIRST_COUNT && cfg_reg == `CFG_JOINED_TIMER && sync_reg
			|=> reg_rdata == load_reg;
	endproperty
	a_count_join: assert property (p_count_join) else $error("joined count readback wrong");
	property p_irq_masked;
		timer_irq |-> $past(mask_reg) != 3'h0;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("interrupt while fully masked");
	property p_trigger_enabled;
		adc_trigger |-> $past(adc_trigger_in) || $past(ctl_reg[`CTL_FIRST_ADC]) || $past(ctl_reg[`CTL_SECOND_ADC]);
	endproperty
	a_trigger_enabled: assert property (p_trigger_enabled) else $error("trigger without enable");
	property p_trigger_or;
		adc_trigger_in |=> adc_trigger;
	endproperty
	a_trigger_or: assert property (p_trigger_or) else $error("trigger input not passed on");

	c_own_trigger: cover property (adc_trigger && !$past(adc_trigger_in));
	c_irq_rise: cover property ($rose(timer_irq));
	c_rtc_read: cover property (reg_rd && cfg_reg == `CFG_JOINED_RTC);
endmodule // gp_timer_asserts

bind gp_timer_32bit_modes gp_timer_asserts #(.RTC_EDGES_PER_SECOND(RTC_EDGES_PER_SECOND)) chk (
	.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_halt(debug_halt), .capture_pin_zero(capture_pin_zero),
	.adc_trigger_in(adc_trigger_in), .adc_trigger(adc_trigger), .timer_irq(timer_irq)
);

// ---- hdl/gp_timer_32bit_modes.sv ----
// General timer module: two 16-bit counters, split or joined, with joined one-shot,
// periodic and real-time-clock modes, event flags, trigger output and debug freeze in joined timer and split modes.
// Assumes a register master on clk_sys, a halt level from the debug logic on clk_sys,
// and a 32.768 kHz clock from outside on capture_pin_zero.
`include "gp_timer_defs.svh"

module gp_timer_32bit_modes
	import gp_timer_pkg::*;
#(
	parameter int RTC_EDGES_PER_SECOND = `RTC_EDGES_PER_SECOND
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic debug_halt,
	input wire logic capture_pin_zero,
	input wire logic adc_trigger_in,
	output logic adc_trigger,
	output logic timer_irq
);

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [2:0] timer_config_reg;
	logic [1:0] first_timer_mode_reg;
	logic [1:0] second_timer_mode_reg;
	ctl_type timer_control_reg;
	irq_type irq_mask_reg;
	irq_type raw_irq_status_reg;
	logic [15:0] load_reg [0:1];
	logic [15:0] match_reg [0:1];
	logic [7:0] first_prescale_reg;
	logic [7:0] second_prescale_reg;
	logic [15:0] count_reg [0:1];
	logic [1:0] load_pend_reg;
	logic rtc_seen_reg;
	logic rtc_first_load_reg;
	logic [31:0] rdata_reg;
	logic trigger_reg;
	logic irq_reg;
	logic [2:0] pin_sync_reg;
	logic [15:0] rtc_div_reg;

	// ------------------------------------------------------------------------
	// Decode and events
	// ------------------------------------------------------------------------
	logic joined;
	logic joined_timer;
	logic joined_rtc;
	logic [31:0] join_count;
	logic [31:0] join_match;
	logic wr_load0;
	logic wr_load1;
	logic pin_rise;
	logic second_tick;
	logic join_tick;
	logic join_zero;
	logic join_one_shot;
	logic rtc_step;
	logic rtc_hit;
	logic [1:0] half_tick;
	logic [1:0] half_zero;
	logic [1:0] half_one_shot;
	logic [1:0] half_run;
	logic [1:0] half_freeze;
	logic [1:0] half_adc;
	irq_type irq_set;
	irq_type irq_clr;
	irq_type wdata_irq;
	logic [31:0] ctl_word;
	logic [31:0] raw_word;
	logic [31:0] masked_word;

	assign joined_timer = timer_config_reg == `CFG_JOINED_TIMER;
	assign joined_rtc = timer_config_reg == `CFG_JOINED_RTC;
	assign joined = joined_timer || joined_rtc;
	assign join_count = {count_reg[1], count_reg[0]};
	assign join_match = {match_reg[1], match_reg[0]};
	assign wr_load0 = reg_wr && reg_addr == `OFS_FIRST_LOAD;
	assign wr_load1 = reg_wr && reg_addr == `OFS_SECOND_LOAD;

	assign half_run = {timer_control_reg.second_run_enable, timer_control_reg.first_run_enable};
	assign half_freeze = {timer_control_reg.second_debug_freeze, timer_control_reg.first_debug_freeze};
	assign half_adc = {timer_control_reg.second_adc_trigger_enable, timer_control_reg.first_adc_trigger_enable};
	assign half_one_shot = {second_timer_mode_reg == `MODE_ONE_SHOT, first_timer_mode_reg == `MODE_ONE_SHOT};

	// Only the second and third stages are compared, the first just settles the pin.
	assign pin_rise = pin_sync_reg[1] && !pin_sync_reg[2];
	assign second_tick = pin_rise && rtc_div_reg == 16'(RTC_EDGES_PER_SECOND - 1);

	assign join_one_shot = first_timer_mode_reg == `MODE_ONE_SHOT;
	assign join_tick = joined_timer && timer_control_reg.first_run_enable
		&& !(timer_control_reg.first_debug_freeze && debug_halt);
	assign join_zero = join_tick && join_count == 32'h00000000;
	assign rtc_step = joined_rtc && timer_control_reg.first_run_enable && second_tick;
	assign rtc_hit = rtc_step && join_count == join_match;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			half_tick[i] = timer_config_reg == `CFG_SPLIT && half_run[i] && !(half_freeze[i] && debug_halt);
			half_zero[i] = half_tick[i] && count_reg[i] == 16'h0000;
		end
	end

	always_comb begin
		irq_set.first_timeout = join_zero || half_zero[0];
		irq_set.rtc_match = rtc_hit;
		irq_set.second_timeout = half_zero[1];
	end

	assign wdata_irq.first_timeout = reg_wdata[`IRQ_FIRST_TIMEOUT];
	assign wdata_irq.rtc_match = reg_wdata[`IRQ_RTC_MATCH];
	assign wdata_irq.second_timeout = reg_wdata[`IRQ_SECOND_TIMEOUT];
	assign irq_clr = (reg_wr && reg_addr == `OFS_IRQ_CLEAR) ? wdata_irq : '0;

	// ------------------------------------------------------------------------
	// Configuration and control
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer_config_reg <= `CONFIG_RESET;
			first_timer_mode_reg <= `MODE_RESET;
			second_timer_mode_reg <= `MODE_RESET;
			irq_mask_reg <= '0;
			first_prescale_reg <= `PRESCALE_RESET;
			second_prescale_reg <= `PRESCALE_RESET;
		end else if (reg_wr) begin
			if (reg_addr == `OFS_CONFIG) begin
				timer_config_reg <= reg_wdata[2:0];
			end else if (reg_addr == `OFS_FIRST_MODE) begin
				first_timer_mode_reg <= reg_wdata[1:0];
			end else if (reg_addr == `OFS_SECOND_MODE) begin
				second_timer_mode_reg <= reg_wdata[1:0];
			end else if (reg_addr == `OFS_IRQ_MASK) begin
				irq_mask_reg <= wdata_irq;
			end else if (reg_addr == `OFS_FIRST_PRESCALE) begin
				first_prescale_reg <= reg_wdata[7:0];
			end else if (reg_addr == `OFS_SECOND_PRESCALE) begin
				second_prescale_reg <= reg_wdata[7:0];
			end
		end
	end

	// A software write to control takes precedence over a hardware stop in the same cycle.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer_control_reg <= '0;
		end else if (reg_wr && reg_addr == `OFS_CONTROL) begin
			timer_control_reg.first_run_enable <= reg_wdata[`CTL_FIRST_RUN];
			timer_control_reg.first_debug_freeze <= reg_wdata[`CTL_FIRST_FREEZE];
			timer_control_reg.rtc_run_enable <= reg_wdata[`CTL_RTC_RUN];
			timer_control_reg.first_adc_trigger_enable <= reg_wdata[`CTL_FIRST_ADC];
			timer_control_reg.second_run_enable <= reg_wdata[`CTL_SECOND_RUN];
			timer_control_reg.second_debug_freeze <= reg_wdata[`CTL_SECOND_FREEZE];
			timer_control_reg.second_adc_trigger_enable <= reg_wdata[`CTL_SECOND_ADC];
		end else begin
			if ((join_zero && join_one_shot) || (half_zero[0] && half_one_shot[0])) begin
				timer_control_reg.first_run_enable <= 1'b0;
			end
			if (half_zero[1] && half_one_shot[1]) begin
				timer_control_reg.second_run_enable <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Load and match registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			load_reg[0] <= `LOAD_RESET;
			load_reg[1] <= `LOAD_RESET;
			match_reg[0] <= `MATCH_RESET;
			match_reg[1] <= `MATCH_RESET;
		end else if (reg_wr) begin
			if (reg_addr == `OFS_FIRST_LOAD) begin
				load_reg[0] <= reg_wdata[15:0];
				if (joined) begin
					load_reg[1] <= reg_wdata[31:16];
				end
			end else if (reg_addr == `OFS_SECOND_LOAD) begin
				load_reg[1] <= reg_wdata[15:0];
			end else if (reg_addr == `OFS_FIRST_MATCH) begin
				match_reg[0] <= reg_wdata[15:0];
				if (joined) begin
					match_reg[1] <= reg_wdata[31:16];
				end
			end else if (reg_addr == `OFS_SECOND_MATCH) begin
				match_reg[1] <= reg_wdata[15:0];
			end
		end
	end

	// In split mode a load write, and in joined timer mode a first load write, is applied to the counter in the following cycle.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			load_pend_reg <= 2'b00;
		end else begin
			load_pend_reg[0] <= wr_load0;
			load_pend_reg[1] <= wr_load1 || (wr_load0 && joined);
		end
	end

	// ------------------------------------------------------------------------
	// Real-time-clock input and first selection
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_sync_reg <= 3'b000;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], capture_pin_zero};
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rtc_div_reg <= 16'h0000;
		end else if (!(joined_rtc && timer_control_reg.first_run_enable)) begin
			rtc_div_reg <= 16'h0000;
		end else if (second_tick) begin
			rtc_div_reg <= 16'h0000;
		end else if (pin_rise) begin
			rtc_div_reg <= rtc_div_reg + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rtc_seen_reg <= 1'b0;
			rtc_first_load_reg <= 1'b0;
		end else begin
			rtc_first_load_reg <= 1'b0;
			if (reg_wr && reg_addr == `OFS_CONFIG && reg_wdata[2:0] == `CFG_JOINED_RTC && !rtc_seen_reg) begin
				rtc_seen_reg <= 1'b1;
				rtc_first_load_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_reg[0] <= `COUNT_RESET;
			count_reg[1] <= `COUNT_RESET;
		end else if (rtc_first_load_reg) begin
			{count_reg[1], count_reg[0]} <= `RTC_FIRST_LOAD;
		end else if (joined) begin
			if (load_pend_reg[0] && joined_timer) begin
				{count_reg[1], count_reg[0]} <= {load_reg[1], load_reg[0]};
			end else if (join_zero) begin
				{count_reg[1], count_reg[0]} <= {load_reg[1], load_reg[0]};
			end else if (join_tick) begin
				{count_reg[1], count_reg[0]} <= join_count - 32'h00000001;
			end else if (rtc_hit) begin
				{count_reg[1], count_reg[0]} <= 32'h00000000;
			end else if (rtc_step) begin
				{count_reg[1], count_reg[0]} <= join_count + 32'h00000001;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (load_pend_reg[i] || half_zero[i]) begin
					count_reg[i] <= load_reg[i];
				end else if (half_tick[i]) begin
					count_reg[i] <= count_reg[i] - 16'h0001;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Event flags, interrupt and trigger
	// ------------------------------------------------------------------------
	// A new event in the cycle of a clear write keeps its flag set.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			raw_irq_status_reg <= '0;
		end else begin
			raw_irq_status_reg <= irq_set | (raw_irq_status_reg & ~irq_clr);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(raw_irq_status_reg & irq_mask_reg);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			trigger_reg <= 1'b0;
		end else begin
			trigger_reg <= adc_trigger_in
				|| (join_zero && timer_control_reg.first_adc_trigger_enable)
				|| |(half_zero & half_adc);
		end
	end

	// ------------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------------
	always_comb begin
		ctl_word = 32'h00000000;
		ctl_word[`CTL_FIRST_RUN] = timer_control_reg.first_run_enable;
		ctl_word[`CTL_FIRST_FREEZE] = timer_control_reg.first_debug_freeze;
		ctl_word[`CTL_RTC_RUN] = timer_control_reg.rtc_run_enable;
		ctl_word[`CTL_FIRST_ADC] = timer_control_reg.first_adc_trigger_enable;
		ctl_word[`CTL_SECOND_RUN] = timer_control_reg.second_run_enable;
		ctl_word[`CTL_SECOND_FREEZE] = timer_control_reg.second_debug_freeze;
		ctl_word[`CTL_SECOND_ADC] = timer_control_reg.second_adc_trigger_enable;
		raw_word = 32'h00000000;
		raw_word[`IRQ_FIRST_TIMEOUT] = raw_irq_status_reg.first_timeout;
		raw_word[`IRQ_RTC_MATCH] = raw_irq_status_reg.rtc_match;
		raw_word[`IRQ_SECOND_TIMEOUT] = raw_irq_status_reg.second_timeout;
		masked_word = 32'h00000000;
		masked_word[`IRQ_FIRST_TIMEOUT] = raw_irq_status_reg.first_timeout && irq_mask_reg.first_timeout;
		masked_word[`IRQ_RTC_MATCH] = raw_irq_status_reg.rtc_match && irq_mask_reg.rtc_match;
		masked_word[`IRQ_SECOND_TIMEOUT] = raw_irq_status_reg.second_timeout && irq_mask_reg.second_timeout;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_reg <= 32'h00000000;
		end else if (reg_rd) begin
			if (reg_addr == `OFS_CONFIG) begin
				rdata_reg <= {29'h0, timer_config_reg};
			end else if (reg_addr == `OFS_FIRST_MODE) begin
				rdata_reg <= {30'h0, first_timer_mode_reg};
			end else if (reg_addr == `OFS_SECOND_MODE) begin
				rdata_reg <= {30'h0, second_timer_mode_reg};
			end else if (reg_addr == `OFS_CONTROL) begin
				rdata_reg <= ctl_word;
			end else if (reg_addr == `OFS_IRQ_MASK) begin
				rdata_reg <= {23'h0, irq_mask_reg.second_timeout, 4'h0, irq_mask_reg.rtc_match,
					2'h0, irq_mask_reg.first_timeout};
			end else if (reg_addr == `OFS_RAW_STATUS) begin
				rdata_reg <= raw_word;
			end else if (reg_addr == `OFS_MASKED_STATUS) begin
				rdata_reg <= masked_word;
			end else if (reg_addr == `OFS_FIRST_LOAD) begin
				rdata_reg <= joined ? {load_reg[1], load_reg[0]} : {16'h0000, load_reg[0]};
			end else if (reg_addr == `OFS_SECOND_LOAD) begin
				rdata_reg <= {16'h0000, load_reg[1]};
			end else if (reg_addr == `OFS_FIRST_MATCH) begin
				rdata_reg <= joined ? join_match : {16'h0000, match_reg[0]};
			end else if (reg_addr == `OFS_SECOND_MATCH) begin
				rdata_reg <= {16'h0000, match_reg[1]};
			end else if (reg_addr == `OFS_FIRST_PRESCALE) begin
				rdata_reg <= {24'h000000, first_prescale_reg};
			end else if (reg_addr == `OFS_SECOND_PRESCALE) begin
				rdata_reg <= {24'h000000, second_prescale_reg};
			end else if (reg_addr == `OFS_FIRST_COUNT) begin
				rdata_reg <= joined ? join_count : {16'h0000, count_reg[0]};
			end else if (reg_addr == `OFS_SECOND_COUNT) begin
				rdata_reg <= {16'h0000, count_reg[1]};
			end else begin
				rdata_reg <= 32'h00000000;
			end
		end
	end

	assign reg_rdata = rdata_reg;
	assign adc_trigger = trigger_reg;
	assign timer_irq = irq_reg;

endmodule // gp_timer_32bit_modes

// ---- hdl/gp_timer_defs.svh ----
// Register offsets, field positions, reset values and codes of the general timer module.
// Assumes byte addresses on an 8-bit register address port with one 32-bit word per register.
`ifndef GP_TIMER_DEFS_SVH
`define GP_TIMER_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CONFIG 8'h00
`define OFS_FIRST_MODE 8'h04
`define OFS_SECOND_MODE 8'h08
`define OFS_CONTROL 8'h0c
`define OFS_IRQ_MASK 8'h18
`define OFS_RAW_STATUS 8'h1c
`define OFS_MASKED_STATUS 8'h20
`define OFS_IRQ_CLEAR 8'h24
`define OFS_FIRST_LOAD 8'h28
`define OFS_SECOND_LOAD 8'h2c
`define OFS_FIRST_MATCH 8'h30
`define OFS_SECOND_MATCH 8'h34
`define OFS_FIRST_PRESCALE 8'h38
`define OFS_SECOND_PRESCALE 8'h3c
`define OFS_FIRST_COUNT 8'h48
`define OFS_SECOND_COUNT 8'h4c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTL_FIRST_RUN 0
`define CTL_FIRST_FREEZE 1
`define CTL_RTC_RUN 4
`define CTL_FIRST_ADC 5
`define CTL_SECOND_RUN 8
`define CTL_SECOND_FREEZE 9
`define CTL_SECOND_ADC 13
`define IRQ_FIRST_TIMEOUT 0
`define IRQ_RTC_MATCH 3
`define IRQ_SECOND_TIMEOUT 8

// ----------------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------------
`define CFG_JOINED_TIMER 3'h0
`define CFG_JOINED_RTC 3'h1
`define CFG_SPLIT 3'h4
`define MODE_ONE_SHOT 2'h1
`define MODE_PERIODIC 2'h2
`define CONFIG_RESET 3'h0
`define MODE_RESET 2'h0
`define LOAD_RESET 16'hffff
`define COUNT_RESET 16'hffff
`define MATCH_RESET 16'hffff
`define PRESCALE_RESET 8'h00
`define RTC_FIRST_LOAD 32'h00000001
`define RTC_EDGES_PER_SECOND 32768

`endif

// ---- hdl/gp_timer_pkg.sv ----
// Types shared by the general timer module.
// Assumes the constants of gp_timer_defs.svh for field positions.
package gp_timer_pkg;

	// Control fields held by the control register.
	typedef struct packed {
		logic second_adc_trigger_enable;
		logic second_debug_freeze;
		logic second_run_enable;
		logic first_adc_trigger_enable;
		logic rtc_run_enable;
		logic first_debug_freeze;
		logic first_run_enable;
	} ctl_type;

	// Sticky event flags.
	typedef struct packed {
		logic second_timeout;
		logic rtc_match;
		logic first_timeout;
	} irq_type;

endpackage
